/* File: hw/cca_pkg.sv */
// Shared constants and types for the cascaded convolver alignment block
package cca_pkg;

	// Array geometry of one device
	localparam int unsigned KW       = 7;
	localparam int unsigned KH       = 3;
	localparam int unsigned NTAP     = KW * KH;

	// Data widths
	localparam int unsigned DW       = 8;
	localparam int unsigned CW       = 8;
	localparam int unsigned SW       = 22;
	localparam int unsigned DLY_AW   = 11;
	localparam int unsigned CNT_W    = 8;

	// Fixed latencies in clock cycles
	localparam int unsigned REF_LAT  = 30;
	localparam int unsigned BACK_LAT = 6;
	localparam int unsigned DIR_LAT  = 2;

	// Alignment constants of the cascade arithmetic
	localparam int ROW_EXTRA  = 7;
	localparam int HORIZ_STEP = 3;
	localparam int VERT_OFFS  = 13;
	localparam int GRID_MUL   = 7;
	localparam int GRID_OFFS  = 20;

	// Reset values
	localparam logic [DLY_AW-1:0] RST_DLY = 11'h000;

	typedef enum logic [1:0] {
		CCA_SINGLE,
		CCA_HORIZ,
		CCA_VERT,
		CCA_GRID
	} cca_mode_t;

endpackage

/* File: hw/cca_link_if.sv */
// Link between a configuring upstream neighbour and one convolver device
`timescale 1ns/1ns
interface cca_link_if;
	logic [cca_pkg::DW-1:0]              pix;
	logic [cca_pkg::SW-1:0]              psum;
	logic                                route_thru;
	logic [cca_pkg::DLY_AW-1:0]          row_len;
	logic [cca_pkg::DLY_AW-1:0]          first_dly;
	logic [cca_pkg::NTAP*cca_pkg::CW-1:0] coef;
	logic                                cfg_ok;

	modport feeder (
		output pix,
		output psum,
		output route_thru,
		output row_len,
		output first_dly,
		output coef,
		output cfg_ok
	);

	modport conv (
		input  pix,
		input  psum,
		input  route_thru,
		input  row_len,
		input  first_dly,
		input  coef,
		input  cfg_ok
	);
endinterface

/* File: hw/cca_dly.sv */
// Programmable-length delay line held in a circular buffer
`timescale 1ns/1ns
module cca_dly #(
	parameter int unsigned W  = 8,
	parameter int unsigned AW = 11
) (
	// Clock and control
	input  wire logic          i_clk_sys,
	input  wire logic          i_srst,
	input  wire logic          i_ce,
	// Length in cycles, zero passes straight through
	input  wire logic [AW-1:0] i_len,
	// Data
	input  wire logic [W-1:0]  i_d,
	output logic      [W-1:0]  o_q
);
	logic [W-1:0]  mem [2**AW];
	logic [AW-1:0] ptr_ff;
	logic [AW-1:0] rd_addr;

	if (W == 0 || AW < 3 || AW > 16)
		$error("cca_dly: unsupported width or depth");

	// Slot written i_len cycles ago; wraps modulo depth
	assign rd_addr = ptr_ff - i_len;
	assign o_q     = (i_len == '0) ? i_d : mem[rd_addr];

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			ptr_ff <= '0;
		else if (i_ce)
			ptr_ff <= ptr_ff + 1'b1;
	end

	// Contents are not reset; stale samples flush after one line
	always_ff @(posedge i_clk_sys)
	begin
		if (i_ce)
			mem[ptr_ff] <= i_d;
	end
endmodule

/* File: hw/cca_conv.sv */
// Convolver device end: delay lines, multiplier array and cascade adder
`timescale 1ns/1ns
module cca_conv #(
	parameter int unsigned AW = cca_pkg::DLY_AW
) (
	// Clock, reset and enable
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_srst,
	input  wire logic                    i_ce,
	// Upstream link
	cca_link_if.conv                     lnk,
	// Downstream cascade outputs
	output logic [cca_pkg::DW-1:0]       o_pix,
	output logic [cca_pkg::SW-1:0]       o_sum,
	// Status
	output logic                         o_route_thru,
	output logic                         o_cfg_valid
);
	localparam int unsigned DW = cca_pkg::DW;
	localparam int unsigned CW = cca_pkg::CW;
	localparam int unsigned SW = cca_pkg::SW;
	localparam int unsigned KW = cca_pkg::KW;
	localparam int unsigned KH = cca_pkg::KH;
	localparam int unsigned RL = cca_pkg::REF_LAT;
	localparam int unsigned BL = cca_pkg::BACK_LAT;

	if (AW != cca_pkg::DLY_AW)
		$error("cca_conv: delay address width must match the link");
	if (RL < 2 || BL < 2)
		$error("cca_conv: latencies too short for the pipeline");

	// Configuration held from the link
	logic                     route_thru_ff;
	logic [AW-1:0]            row_len_ff;
	logic [AW-1:0]            first_dly_ff;
	logic [CW-1:0]            coef_ff [KH][KW];
	logic                     cfg_valid_ff;

	// Pixel path
	logic [DW-1:0]            pix_in_ff;
	logic [DW-1:0]            pix_dir_ff;
	logic [DW-1:0]            first_q;
	logic [DW-1:0]            row_in [KH];
	logic [DW-1:0]            tap_ff [KH][KW];

	// Arithmetic path
	logic signed [SW-1:0]     nxt_mac;
	logic [SW-1:0]            own_ff [RL-1];
	logic [SW-1:0]            casc_ff [BL-1];
	logic [DW-1:0]            pix_out_ff;
	logic [SW-1:0]            sum_out_ff;

	// Configuration is only taken while the feeder marks it consistent
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			route_thru_ff <= 1'b0;
			row_len_ff    <= cca_pkg::RST_DLY;
			first_dly_ff  <= cca_pkg::RST_DLY;
			cfg_valid_ff  <= 1'b0;
		end
		else if (i_ce)
		begin
			cfg_valid_ff <= lnk.cfg_ok;
			if (lnk.cfg_ok)
			begin
				route_thru_ff <= lnk.route_thru;
				row_len_ff    <= lnk.row_len;
				first_dly_ff  <= lnk.first_dly;
			end
		end
	end

	for (genvar r = 0; r < KH; r++)
	begin : g_coef_r
		for (genvar c = 0; c < KW; c++)
		begin : g_coef_c
			always_ff @(posedge i_clk_sys)
			begin
				if (i_srst)
					coef_ff[r][c] <= '0;
				else if (i_ce && lnk.cfg_ok)
					coef_ff[r][c] <= lnk.coef[(r*KW+c)*CW +: CW];
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			pix_in_ff  <= '0;
			pix_dir_ff <= '0;
		end
		else if (i_ce)
		begin
			pix_in_ff  <= lnk.pix;
			pix_dir_ff <= pix_in_ff;
		end
	end

	cca_dly #(
		.W  (DW),
		.AW (AW)
	) u_first_input_delay (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_ce      (i_ce),
		.i_len     (first_dly_ff),
		.i_d       (pix_in_ff),
		.o_q       (first_q)
	);

	assign row_in[0] = first_q;

	for (genvar r = 1; r < KH; r++)
	begin : g_row_dly
		cca_dly #(
			.W  (DW),
			.AW (AW)
		) u_row_delay_line (
			.i_clk_sys (i_clk_sys),
			.i_srst    (i_srst),
			.i_ce      (i_ce),
			.i_len     (row_len_ff),
			.i_d       (row_in[r-1]),
			.o_q       (row_in[r])
		);
	end

	for (genvar r = 0; r < KH; r++)
	begin : g_tap_r
		always_ff @(posedge i_clk_sys)
		begin
			if (i_srst)
			begin
				for (int c = 0; c < KW; c++)
					tap_ff[r][c] <= '0;
			end
			else if (i_ce)
			begin
				tap_ff[r][0] <= row_in[r];
				for (int c = 1; c < KW; c++)
					tap_ff[r][c] <= tap_ff[r][c-1];
			end
		end
	end

	always_comb
	begin
		nxt_mac = '0;
		for (int r = 0; r < KH; r++)
			for (int c = 0; c < KW; c++)
				nxt_mac = nxt_mac + SW'($signed(coef_ff[r][c]) * $signed({1'b0, tap_ff[r][c]}));
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < RL - 1; i++)
				own_ff[i] <= '0;
		end
		else if (i_ce)
		begin
			own_ff[0] <= nxt_mac;
			for (int i = 1; i < RL - 1; i++)
				own_ff[i] <= own_ff[i-1];
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < BL - 1; i++)
				casc_ff[i] <= '0;
		end
		else if (i_ce)
		begin
			casc_ff[0] <= lnk.psum;
			for (int i = 1; i < BL - 1; i++)
				casc_ff[i] <= casc_ff[i-1];
		end
	end

	// cascade adder
	// Sum wraps at the cascade width; the configurator sizes kernels to fit
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			sum_out_ff <= '0;
		else if (i_ce)
			sum_out_ff <= own_ff[RL-2] + casc_ff[BL-2];
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			pix_out_ff <= '0;
		else if (i_ce)
			pix_out_ff <= route_thru_ff ? row_in[KH-1] : pix_dir_ff;
	end

	assign o_pix        = pix_out_ff;
	assign o_sum        = sum_out_ff;
	assign o_route_thru = route_thru_ff;
	assign o_cfg_valid  = cfg_valid_ff;
endmodule

/* File: hw/cca_feeder.sv */
// Upstream end: computes cascade delays and drives pixels and partial sums
`timescale 1ns/1ns
module cca_feeder #(
	parameter int unsigned AW = cca_pkg::DLY_AW
) (
	// Clock, reset and enable
	input  wire logic                                 i_clk_sys,
	input  wire logic                                 i_srst,
	input  wire logic                                 i_ce,
	// Arrangement of the cascade
	input  wire cca_pkg::cca_mode_t                   i_mode,
	input  wire logic [AW-1:0]                        i_line_len,
	input  wire logic [cca_pkg::CNT_W-1:0]            i_cols,
	input  wire logic [cca_pkg::CNT_W-1:0]            i_col_idx,
	input  wire logic [cca_pkg::CNT_W-1:0]            i_row_idx,
	input  wire logic [AW-1:0]                        i_base_dly,
	// Kernel
	input  wire logic [cca_pkg::NTAP*cca_pkg::CW-1:0] i_coef,
	input  wire logic [2:0]                           i_kern_w,
	input  wire logic [1:0]                           i_kern_h,
	// Stream from further upstream
	input  wire logic [cca_pkg::DW-1:0]               i_pix,
	input  wire logic [cca_pkg::SW-1:0]               i_psum,
	// Status
	output logic                                      o_cfg_err,
	// Link to the device
	cca_link_if.feeder                                lnk
);
	localparam int unsigned CW   = cca_pkg::CW;
	localparam int unsigned KW   = cca_pkg::KW;
	localparam int          DMAX = (2**AW) - 1;

	if (AW != cca_pkg::DLY_AW)
		$error("cca_feeder: delay address width must match the link");

	int   l_len;
	int   m_cols;
	int   col;
	int   nxt_fd;
	int   nxt_row;
	logic nxt_thru;
	logic nxt_err;
	logic [cca_pkg::NTAP*CW-1:0] nxt_coef;

	always_comb
	begin
		l_len   = int'(i_line_len);
		m_cols  = int'(i_cols);
		col     = int'(i_col_idx);
		nxt_row = l_len + cca_pkg::ROW_EXTRA;
		nxt_fd  = int'(i_base_dly);
		nxt_thru = 1'b0;
		unique case (i_mode)
			cca_pkg::CCA_SINGLE:
				nxt_fd = int'(i_base_dly);
			cca_pkg::CCA_HORIZ:
				nxt_fd = int'(i_base_dly) + cca_pkg::HORIZ_STEP * (m_cols - 1 - col);
			cca_pkg::CCA_VERT:
			begin
				nxt_thru = 1'b1;
				if (i_row_idx != '0)
					nxt_fd = l_len - cca_pkg::VERT_OFFS;
			end
			cca_pkg::CCA_GRID:
			begin
				nxt_thru = (col == m_cols - 1);
				if (i_row_idx == '0)
					nxt_fd = int'(i_base_dly) + cca_pkg::HORIZ_STEP * (m_cols - 1 - col);
				else
					nxt_fd = cca_pkg::GRID_MUL * m_cols + l_len - cca_pkg::GRID_OFFS
						- cca_pkg::HORIZ_STEP * col;
			end
		endcase
		nxt_err = (nxt_fd < 0) || (nxt_fd > DMAX) || (nxt_row > DMAX)
			|| (m_cols == 0) || (col >= m_cols);
	end

	for (genvar t = 0; t < cca_pkg::NTAP; t++)
	begin : g_mask
		assign nxt_coef[t*CW +: CW] = (((t % KW) < int'(i_kern_w)) && ((t / KW) < int'(i_kern_h)))
			? i_coef[t*CW +: CW] : '0;
	end

	// A rejected arrangement keeps the last good one applied
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			lnk.route_thru <= 1'b0;
			lnk.row_len    <= cca_pkg::RST_DLY;
			lnk.first_dly  <= cca_pkg::RST_DLY;
			lnk.coef       <= '0;
			lnk.cfg_ok     <= 1'b0;
			o_cfg_err      <= 1'b0;
		end
		else if (i_ce)
		begin
			lnk.cfg_ok <= !nxt_err;
			o_cfg_err  <= nxt_err;
			if (!nxt_err)
			begin
				lnk.route_thru <= nxt_thru;
				lnk.row_len    <= AW'(nxt_row);
				lnk.first_dly  <= AW'(nxt_fd);
				lnk.coef       <= nxt_coef;
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			lnk.pix  <= '0;
			lnk.psum <= '0;
		end
		else if (i_ce)
		begin
			lnk.pix  <= i_pix;
			lnk.psum <= i_psum;
		end
	end
endmodule

/* File: tb/cca_checker.sv */
// Concurrent checks on the feeder to device link and on the device outputs
`timescale 1ns/1ns
module cca_checker (
	// Clock, reset and enable
	input wire logic               i_clk_sys,
	input wire logic               i_srst,
	input wire logic               i_ce,
	// Arrangement given to the feeder
	input wire cca_pkg::cca_mode_t i_mode,
	input wire logic [10:0]        i_line_len,
	input wire logic [7:0]         i_cols,
	input wire logic [7:0]         i_col_idx,
	input wire logic [7:0]         i_row_idx,
	input wire logic [10:0]        i_base_dly,
	// Link
	input wire logic [7:0]         pix,
	input wire logic [21:0]        psum,
	input wire logic               route_thru,
	input wire logic [10:0]        row_len,
	input wire logic [10:0]        first_dly,
	input wire logic [167:0]       coef,
	input wire logic               cfg_ok,
	// Device outputs
	input wire logic [7:0]         o_pix,
	input wire logic [21:0]        o_sum
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	logic               ok_ff;
	cca_pkg::cca_mode_t md_ff;
	logic [10:0]        l_ff;
	logic [10:0]        b_ff;
	logic [7:0]         m_ff;
	logic [7:0]         c_ff;
	logic [7:0]         r_ff;
	logic [6:0]         zc_ff;
	logic [3:0]         dc_ff;

	// Arrangement as the feeder took it on the last edge
	always_ff @(posedge i_clk_sys)
	begin
		ok_ff <= i_ce && !i_srst;
		md_ff <= i_mode;
		l_ff <= i_line_len;
		b_ff <= i_base_dly;
		m_ff <= i_cols;
		c_ff <= i_col_idx;
		r_ff <= i_row_idx;
	end

	// Delay memories are not reset, so sums are judged only once short lines have flushed
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst || !i_ce || coef != '0 || row_len > 11'h010 || first_dly > 11'h010)
			zc_ff <= 7'h00;
		else if (zc_ff != 7'h7F)
			zc_ff <= zc_ff + 7'h01;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst || !i_ce || route_thru)
			dc_ff <= 4'h0;
		else if (dc_ff != 4'hF)
			dc_ff <= dc_ff + 4'h1;
	end

	rowlen_a: assert property (ok_ff && cfg_ok |-> row_len == 11'(l_ff + 11'h007))
		else $error("row delay length wrong");
	horiz_dly_a: assert property (ok_ff && cfg_ok && md_ff == cca_pkg::CCA_HORIZ
		|-> first_dly == 11'(b_ff + 3 * (m_ff - c_ff - 1))) else $error("side first delay wrong");
	vert_dly_a: assert property (ok_ff && cfg_ok && md_ff == cca_pkg::CCA_VERT
		&& r_ff != 8'h00 |-> first_dly == 11'(l_ff - 13)) else $error("stack first delay wrong");
	grid_dly_a: assert property (ok_ff && cfg_ok && md_ff == cca_pkg::CCA_GRID && r_ff != 8'h00
		|-> first_dly == 11'(7 * m_ff + l_ff - 20 - 3 * c_ff)) else $error("grid delay wrong");
	grid_route_a: assert property (ok_ff && cfg_ok && md_ff == cca_pkg::CCA_GRID
		|-> route_thru == (c_ff == m_ff - 8'h01)) else $error("grid route wrong");
	bad_cfg_a: assert property (ok_ff && (m_ff == 8'h00 || c_ff >= m_ff) |-> !cfg_ok)
		else $error("bad arrangement accepted");
	back_lat_a: assert property (zc_ff >= 7'h64 |-> o_sum == $past(psum, 6))
		else $error("cascade sum latency wrong");
	direct_a: assert property (dc_ff >= 4'h8 |-> o_pix == $past(pix, 3))
		else $error("direct pixel path wrong");

	cover property (zc_ff == 7'h64);
	cover property (ok_ff && !cfg_ok);
	cover property (cfg_ok && route_thru);
endmodule

/* File: tb/cascaded_convolver_alignment_tb.sv */
// Feeder and convolver joined by the link, driven from the feeder side and judged from both user sides
`timescale 1ns/1ns
module cascaded_convolver_alignment_tb;
	logic               i_clk_sys = 1'b0;
	logic               i_srst = 1'b1;
	logic               i_ce = 1'b1;
	cca_pkg::cca_mode_t i_mode = cca_pkg::CCA_SINGLE;
	logic [10:0]        i_line_len = 11'h000;
	logic [7:0]         i_cols = 8'h01;
	logic [7:0]         i_col_idx = 8'h00;
	logic [7:0]         i_row_idx = 8'h00;
	logic [10:0]        i_base_dly = 11'h000;
	logic [167:0]       i_coef = '0;
	logic [2:0]         i_kern_w = 3'h7;
	logic [1:0]         i_kern_h = 2'h3;
	logic [7:0]         i_pix = 8'h00;
	logic [21:0]        i_psum = 22'h000000;
	logic               o_cfg_err;
	logic [7:0]         o_pix;
	logic [21:0]        o_sum;
	logic               o_route_thru;
	logic               o_cfg_valid;
	int                 error_cnt = 0;
	int                 total_checks = 0;

	cca_link_if lnk ();
	cca_feeder cca_feeder_inst (.i_clk_sys, .i_srst, .i_ce, .i_mode, .i_line_len, .i_cols,
		.i_col_idx, .i_row_idx, .i_base_dly, .i_coef, .i_kern_w, .i_kern_h, .i_pix, .i_psum,
		.o_cfg_err, .lnk(lnk.feeder));
	cca_conv cca_conv_inst (.i_clk_sys, .i_srst, .i_ce, .lnk(lnk.conv), .o_pix, .o_sum,
		.o_route_thru, .o_cfg_valid);
	cca_checker cca_checker_inst (.i_clk_sys, .i_srst, .i_ce, .i_mode, .i_line_len, .i_cols,
		.i_col_idx, .i_row_idx, .i_base_dly, .pix(lnk.pix), .psum(lnk.psum),
		.route_thru(lnk.route_thru), .row_len(lnk.row_len), .first_dly(lnk.first_dly),
		.coef(lnk.coef), .cfg_ok(lnk.cfg_ok), .o_pix, .o_sum);

	always #2 i_clk_sys = ~i_clk_sys;

	task automatic chk(input logic [167:0] seen, input logic [167:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Link settles one edge after the inputs, the device one edge later
	task automatic cfg(input cca_pkg::cca_mode_t m, input logic [10:0] l, input logic [7:0] mc,
		input logic [7:0] c, input logic [7:0] r, input logic [10:0] b);
		@(negedge i_clk_sys);
		i_mode = m;
		i_line_len = l;
		i_cols = mc;
		i_col_idx = c;
		i_row_idx = r;
		i_base_dly = b;
		repeat (2) @(negedge i_clk_sys);
	endtask

	task automatic dchk(input cca_pkg::cca_mode_t m, input logic [10:0] l, input logic [7:0] mc,
		input logic [7:0] c, input logic [7:0] r, input logic [10:0] b, input logic [10:0] fd,
		input logic th);
		cfg(m, l, mc, c, r, b);
		chk(lnk.first_dly, fd);
		chk(lnk.row_len, l + 11'h007);
		chk({lnk.route_thru, o_route_thru}, {th, th});
		chk({o_cfg_err, lnk.cfg_ok, o_cfg_valid}, 3'h3);
	endtask

	task automatic bad(input cca_pkg::cca_mode_t m, input logic [10:0] l, input logic [7:0] mc,
		input logic [7:0] c);
		cfg(m, l, mc, c, 8'h00, 11'h000);
		chk({o_cfg_err, lnk.cfg_ok, o_cfg_valid}, 3'h4);
		chk({lnk.row_len, lnk.first_dly}, {11'h207, 11'h007});
	endtask

	task automatic t_delays();
		dchk(cca_pkg::CCA_HORIZ, 11'h400, 8'h03, 8'h00, 8'h00, 11'h000, 11'h006, 1'b0);
		dchk(cca_pkg::CCA_HORIZ, 11'h400, 8'h03, 8'h01, 8'h00, 11'h000, 11'h003, 1'b0);
		dchk(cca_pkg::CCA_HORIZ, 11'h400, 8'h03, 8'h02, 8'h00, 11'h000, 11'h000, 1'b0);
		dchk(cca_pkg::CCA_VERT, 11'h200, 8'h01, 8'h00, 8'h00, 11'h000, 11'h000, 1'b1);
		dchk(cca_pkg::CCA_VERT, 11'h200, 8'h01, 8'h00, 8'h02, 11'h000, 11'h1F3, 1'b1);
		dchk(cca_pkg::CCA_GRID, 11'h200, 8'h02, 8'h00, 8'h00, 11'h000, 11'h003, 1'b0);
		dchk(cca_pkg::CCA_GRID, 11'h200, 8'h02, 8'h01, 8'h00, 11'h000, 11'h000, 1'b1);
		dchk(cca_pkg::CCA_GRID, 11'h200, 8'h02, 8'h00, 8'h01, 11'h000, 11'h1FA, 1'b0);
		dchk(cca_pkg::CCA_GRID, 11'h200, 8'h02, 8'h01, 8'h02, 11'h000, 11'h1F7, 1'b1);
		dchk(cca_pkg::CCA_SINGLE, 11'h200, 8'h01, 8'h00, 8'h00, 11'h007, 11'h007, 1'b0);
	endtask

	task automatic t_refuse();
		bad(cca_pkg::CCA_HORIZ, 11'h200, 8'h00, 8'h00);
		bad(cca_pkg::CCA_HORIZ, 11'h200, 8'h02, 8'h02);
		bad(cca_pkg::CCA_SINGLE, 11'h7F9, 8'h01, 8'h00);
	endtask

	task automatic t_kern();
		logic [167:0] e;
		e = '0;
		for (int t = 0; t < 21; t++)
			if (t % 7 < 3 && t / 7 < 2)
				e[t * 8 +: 8] = 8'h01;
		i_coef = {21{8'h01}};
		i_kern_w = 3'h3;
		i_kern_h = 2'h2;
		// A refused arrangement keeps the old kernel, so apply a legal one
		cfg(cca_pkg::CCA_SINGLE, 11'h200, 8'h01, 8'h00, 8'h00, 11'h000);
		chk(lnk.coef, e);
		i_kern_w = 3'h7;
		i_kern_h = 2'h3;
	endtask

	// Pixel and sum histories; early samples skipped while stale memory flushes
	task automatic stream(input int dp, input int ds, input int dr, input logic neg);
		logic [7:0]  hp [100];
		logic [21:0] hs [100];
		for (int i = 0; i < 100; i++)
		begin
			@(negedge i_clk_sys);
			if (i >= 60)
			begin
				chk(o_pix, hp[i - dp]);
				// A tap of minus one subtracts the pixel seen dr cycles back
				chk(o_sum, 22'(hs[i - ds] - (neg ? 22'(hp[i - dr]) : 22'h000000)));
			end
			hp[i] = 8'(i * 37);
			hs[i] = 22'(i * 4099);
			i_pix = hp[i];
			i_psum = hs[i];
		end
	endtask

	task automatic t_stream();
		i_coef = '0;
		cfg(cca_pkg::CCA_SINGLE, 11'h000, 8'h01, 8'h00, 8'h00, 11'h000);
		stream(4, 7, 33, 1'b0);
		cfg(cca_pkg::CCA_VERT, 11'h000, 8'h01, 8'h00, 8'h00, 11'h000);
		stream(17, 7, 33, 1'b0);
		i_coef = {160'h0, 8'hFF};
		cfg(cca_pkg::CCA_SINGLE, 11'h000, 8'h01, 8'h00, 8'h00, 11'h000);
		stream(4, 7, 33, 1'b1);
	endtask

	task automatic t_freeze();
		logic [29:0] s;
		i_ce = 1'b0;
		@(negedge i_clk_sys);
		s = {o_pix, o_sum};
		i_psum = 22'h15A5A5;
		i_pix = 8'hA5;
		repeat (4) @(negedge i_clk_sys);
		chk({o_pix, o_sum}, s);
		i_ce = 1'b1;
	endtask

	initial
	begin
		repeat (12) @(negedge i_clk_sys);
		i_srst = 1'b0;
		chk({lnk.cfg_ok, lnk.first_dly, o_sum, o_cfg_valid}, '0);
		t_delays();
		t_refuse();
		t_kern();
		t_stream();
		t_freeze();
		results();
	end

	initial
	begin
		repeat (20000) @(posedge i_clk_sys);
		error_cnt++;
		results();
	end
endmodule
